/* logic/actd_top.sv */
// Design: auxiliary clock generator and tone clock divider with its two registers
`timescale 1ns/1ps

module actd_top (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire actd_pkg::actd_req_s req,
  output logic [7:0]              rdata,
  output logic                    aux_clk_out,
  output logic                    tone_clk_out
);

  // Register contents and the fields decoded from them
  logic [7:0]                    aux_clock_config;
  logic [7:0]                    tone_divider;
  logic [2:0]                    psel;
  logic [4:0]                    div_field;
  actd_pkg::actd_mode_e          mode;

  // One-cycle restart strobes taken from the register port
  logic                          aux_restart;
  logic                          tone_restart;

  // Shared divide-by-16, the common first stage
  logic [actd_pkg::SHARED_W-1:0] shared_cnt;
  logic                          shared_tick;

  // High-frequency generator path
  logic [actd_pkg::HF_W-1:0]     hf_cnt;
  logic [actd_pkg::HF_W-1:0]     hf_half;
  logic                          hf_wrap;

  // Low-frequency generator path: prescaler stage, then the 32 + divider stage
  logic [actd_pkg::PRE_W-1:0]    pre_cnt;
  logic [actd_pkg::PRE_W-1:0]    pre_half;
  logic                          pre_tick;
  logic [actd_pkg::LFDIV_W-1:0]  lf_cnt;
  logic [actd_pkg::LFDIV_W-1:0]  lf_last;
  logic                          lf_wrap;

  // Tone path behind the shared stage
  logic [actd_pkg::TONE_W-1:0]   tone_cnt;
  logic [actd_pkg::TONE_W-1:0]   tone_half;

  // Field split of the config register
  // Both fields are live at once; the mode picks which of them matters
  assign psel      = aux_clock_config[actd_pkg::PSEL_MSB:actd_pkg::PSEL_LSB];
  assign div_field = aux_clock_config[actd_pkg::DIV_MSB:actd_pkg::DIV_LSB];

  // Mode decode from the prescaler select
  // Every code above 001 is a low-frequency range; the range only changes the prescale
  always_comb begin
    if (psel == actd_pkg::PSEL_PORT) begin
      mode = actd_pkg::ACTD_MODE_PORT;
    end else if (psel == actd_pkg::PSEL_HF) begin
      mode = actd_pkg::ACTD_MODE_HF;
    end else begin
      mode = actd_pkg::ACTD_MODE_LF;
    end
  end

  // Restart strobes; a read of the tone register counts as an access too
  // Reading the aux register leaves the aux clock running undisturbed
  assign aux_restart  = req.wr && (req.addr == actd_pkg::ADDR_AUX_CLOCK_CONFIG);
  assign tone_restart = (req.wr || req.rd) &&
                        (req.addr == actd_pkg::ADDR_TONE_DIVIDER);

  // Register writes
  // Unmapped addresses are ignored, so a stray write cannot disturb the generators
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aux_clock_config <= actd_pkg::RST_AUX_CLOCK_CONFIG;
      tone_divider     <= actd_pkg::RST_TONE_DIVIDER;
    end else if (req.wr) begin
      if (req.addr == actd_pkg::ADDR_AUX_CLOCK_CONFIG) begin
        aux_clock_config <= req.wdata;
      end else if (req.addr == actd_pkg::ADDR_TONE_DIVIDER) begin
        tone_divider <= req.wdata;
      end
    end
  end

  // Read data, one cycle after the read; other addresses read zero
  // Holding rdata between reads lets a slow bus decoder take it at leisure
  // Read data comes from a flip-flop, never straight from the address decode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == actd_pkg::ADDR_AUX_CLOCK_CONFIG) begin
        rdata <= aux_clock_config;
      end else if (req.addr == actd_pkg::ADDR_TONE_DIVIDER) begin
        rdata <= tone_divider;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // Shared divide-by-16; both the tone path and the low-frequency aux path hang off it
  // An aux write never clears it, so only a tone access moves the shared ticks that the low-frequency steps count
  assign shared_tick = (shared_cnt == actd_pkg::SHARED_W'(actd_pkg::SHARED_DIV - 1));
  always_ff @(posedge clock) begin
    if (!rst_n || tone_restart) begin
      shared_cnt <= '0;
    end else begin
      shared_cnt <= shared_cnt + 1'b1;
    end
  end

  // High-frequency half period: 4 * divider vco cycles gives an 8 * divider full period
  // The product stays below 128 because the divider field is at most 31
  assign hf_half = actd_pkg::HF_W'(actd_pkg::HF_HALF_MULT) *
                   actd_pkg::HF_W'(div_field);

  // End of a high-frequency half period, shared by the counter and the output
  assign hf_wrap = (hf_cnt >= hf_half - 1'b1);

  // Low-frequency half period: prescale * 4 shared ticks per prescaler step, then 32 + divider
  // The longest step is 8192 shared ticks, hence the 14-bit prescaler counter
  // A restart cannot align the step to the shared stage, so the first one may be 15 cycles short
  assign pre_half = actd_pkg::PRE_W'(actd_pkg::LF_HALF_MULT * actd_pkg::LF_MIN_PRESCALE)
                    << (psel - 3'h2);
  assign pre_tick = shared_tick && (pre_cnt == pre_half - 1'b1);
  assign lf_last  = actd_pkg::LFDIV_W'(actd_pkg::LF_DIV_OFFSET) + actd_pkg::LFDIV_W'(div_field)
                    - 1'b1;
  assign lf_wrap  = pre_tick && (lf_cnt == lf_last);

  // High-frequency counter; a zero divider holds the output low rather than run away
  // Held at zero outside its mode, so entering it always starts a full half period
  always_ff @(posedge clock) begin
    if (!rst_n || aux_restart || mode != actd_pkg::ACTD_MODE_HF) begin
      hf_cnt <= '0;
    end else if (hf_wrap) begin
      hf_cnt <= '0;
    end else begin
      hf_cnt <= hf_cnt + 1'b1;
    end
  end

  // Low-frequency prescaler stage, stepping on shared ticks
  // Held at zero outside its mode, like the high-frequency counter
  always_ff @(posedge clock) begin
    if (!rst_n || aux_restart || mode != actd_pkg::ACTD_MODE_LF) begin
      pre_cnt <= '0;
    end else if (pre_tick) begin
      pre_cnt <= '0;
    end else if (shared_tick) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // Low-frequency programmable divider, 32 + divider prescaler steps per half period
  // Its last count is at most 62, so six bits never overflow
  always_ff @(posedge clock) begin
    if (!rst_n || aux_restart || mode != actd_pkg::ACTD_MODE_LF) begin
      lf_cnt <= '0;
    end else if (pre_tick) begin
      lf_cnt <= (lf_cnt == lf_last) ? '0 : lf_cnt + 1'b1;
    end
  end

  // Aux output: toggling at each half period keeps high and low equal
  // A restart parks the output low for one cycle before a new port level shows
  // In port mode the level follows bit 0 one cycle after the register takes it
  always_ff @(posedge clock) begin
    if (!rst_n || aux_restart) begin
      aux_clk_out <= 1'b0;
    end else begin
      case (mode)
        actd_pkg::ACTD_MODE_PORT: begin
          aux_clk_out <= aux_clock_config[0];
        end
        actd_pkg::ACTD_MODE_HF: begin
          if (div_field == 5'h00) begin
            aux_clk_out <= 1'b0;
          end else if (hf_wrap) begin
            aux_clk_out <= ~aux_clk_out;
          end
        end
        default: begin
          if (lf_wrap) begin
            aux_clk_out <= ~aux_clk_out;
          end
        end
      endcase
    end
  end

  // Tone half period: 4 * R shared ticks, so a full period of 128 * R vco cycles
  // The largest setting gives 1020 ticks, which fits the 10-bit counter
  assign tone_half = actd_pkg::TONE_W'(actd_pkg::TONE_HALF_MULT) *
                     actd_pkg::TONE_W'(tone_divider);

  // Tone divider; a zero setting holds the tone low
  // Without that guard a zero setting would wrap the counter into a 1024-tick half period
  // The first toggle after a restart lands 64 times the setting cycles later
  always_ff @(posedge clock) begin
    if (!rst_n || tone_restart) begin
      tone_cnt     <= '0;
      tone_clk_out <= 1'b0;
    end else if (tone_divider == 8'h00) begin
      tone_cnt     <= '0;
      tone_clk_out <= 1'b0;
    end else if (shared_tick) begin
      if (tone_cnt == tone_half - 1'b1) begin
        tone_cnt     <= '0;
        tone_clk_out <= ~tone_clk_out;
      end else begin
        tone_cnt <= tone_cnt + 1'b1;
      end
    end
  end

endmodule

/* shared/actd_pkg.sv */
// Package: register map, reset values and divider constants for the aux clock / tone block
package actd_pkg;

  // Register addresses on the register port
  localparam logic [7:0] ADDR_AUX_CLOCK_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_TONE_DIVIDER     = 8'h04;

  // Values after reset
  localparam logic [7:0] RST_AUX_CLOCK_CONFIG = 8'h2A;
  localparam logic [7:0] RST_TONE_DIVIDER     = 8'h8E;

  // Field positions inside the aux clock configuration register
  localparam int PSEL_MSB = 7;
  localparam int PSEL_LSB = 5;
  localparam int DIV_MSB  = 4;
  localparam int DIV_LSB  = 0;

  // Prescaler-select codes
  localparam logic [2:0] PSEL_PORT = 3'h0;
  localparam logic [2:0] PSEL_HF   = 3'h1;

  // Divider constants, in cycles of the vco clock
  localparam int SHARED_DIV      = 16;   // Common first stage
  localparam int HF_PRE_DIV      = 8;    // High-frequency fixed stage
  localparam int LF_PRE_DIV      = 128;  // Low-frequency fixed stage
  localparam int LF_DIV_OFFSET   = 32;   // Added to the divider field
  localparam int TONE_PRE_DIV    = 128;  // Tone fixed stage
  localparam int LF_MIN_PRESCALE = 64;   // Prescale of code 010

  // Half periods per prescale unit: vco cycles for the high-frequency path, shared-stage ticks for the others
  localparam int HF_HALF_MULT   = HF_PRE_DIV / 2;
  localparam int LF_HALF_MULT   = LF_PRE_DIV / (2 * SHARED_DIV);
  localparam int TONE_HALF_MULT = TONE_PRE_DIV / (2 * SHARED_DIV);

  // Counter widths
  localparam int SHARED_W = 4;
  localparam int HF_W     = 7;
  localparam int PRE_W    = 14;
  localparam int LFDIV_W  = 6;
  localparam int TONE_W   = 10;

  // Generator mode, one-hot
  typedef enum logic [2:0] {
    ACTD_MODE_PORT = 3'b001,
    ACTD_MODE_HF   = 3'b010,
    ACTD_MODE_LF   = 3'b100
  } actd_mode_e;

  // One register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } actd_req_s;

endpackage

/* bench/actd_top_chk.sv */
// Checker: port relations of the aux clock and tone divider block
`timescale 1ns/1ps
module actd_top_chk (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire actd_pkg::actd_req_s req,
  input wire logic [7:0]          rdata,
  input wire logic                aux_clk_out,
  input wire logic                tone_clk_out
);
  logic [7:0]  cfg;
  logic [7:0]  tdiv;
  logic [15:0] tcnt;
  logic        tprev;
  logic        tseen;
  logic        acc_d;
  wire         wr3 = req.wr && req.addr == 8'h03;
  wire         acc4 = (req.wr || req.rd) && req.addr == 8'h04;
  wire         tog = tone_clk_out ^ tprev;
  // Shadow registers, so the mode is known without the design's state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg <= actd_pkg::RST_AUX_CLOCK_CONFIG;
      tdiv <= actd_pkg::RST_TONE_DIVIDER;
    end else begin
      if (wr3) cfg <= req.wdata;
      if (req.wr && req.addr == 8'h04) tdiv <= req.wdata;
    end
  end
  // Tone edge spacing; first edge after a restart is skipped, as tcnt there starts one cycle late
  always_ff @(posedge clock) begin
    tprev <= tone_clk_out;
    acc_d <= acc4;
    if (!rst_n || acc4 || acc_d) begin
      tcnt <= 16'h0000;
      tseen <= 1'b0;
    end else if (tog) begin
      tcnt <= 16'h0001;
      tseen <= 1'b1;
    end else tcnt <= tcnt + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_RD_MAP: assert property (req.rd && !req.wr && wr3 == 1'b0 && req.addr == 8'h03
    |=> rdata == $past(cfg)) else $error("aux config readback wrong");
  AST_RD_UNMAPPED: assert property (req.rd && req.addr != 8'h03 && req.addr != 8'h04
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  AST_PORT_LEVEL: assert property (wr3 && req.wdata[7:5] == 3'h0 ##1 !wr3
    |=> aux_clk_out == $past(cfg[0])) else $error("port level wrong");
  AST_LF_QUIET: assert property (wr3 && req.wdata[7:6] != 2'h0 ##1 (!wr3) [*7]
    |-> !aux_clk_out) else $error("low range toggled early");
  AST_HF_HALF: assert property (cfg == 8'h21 && $rose(aux_clk_out)
    ##1 (!wr3) [*3] |-> aux_clk_out ##1 !aux_clk_out) else $error("fast half period wrong");
  AST_TONE_HALF: assert property (tog && tseen |-> tcnt == {2'h0, tdiv, 6'h00})
    else $error("tone half period wrong");
  AST_TONE_RESTART: assert property (acc4 |=> !tone_clk_out)
    else $error("tone not restarted");
  AST_AUX_RESTART: assert property (wr3 |=> !aux_clk_out)
    else $error("aux not restarted");
endmodule
bind actd_top actd_top_chk u_chk (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
  .aux_clk_out(aux_clk_out), .tone_clk_out(tone_clk_out));

/* bench/actd_top_tb.sv */
// Testbench: registers, aux clock and tone clock of actd_top
`timescale 1ns/1ps
module actd_top_tb;
  logic                clock;
  logic                rst_n;
  actd_pkg::actd_req_s req;
  logic [7:0]          rdata;
  logic                aux_clk_out;
  logic                tone_clk_out;
  int                  bad_count;
  int                  n_tests;
  int                  cyc;
  actd_top dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .aux_clk_out(aux_clk_out), .tone_clk_out(tone_clk_out));
  always #5 clock = ~clock;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One register cycle; strobe drops at the edge that takes it
  task access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask
  // Cycles between two edges of aux (t=0) or tone (t=1), sampled just after each edge
  task half(input logic t, input int exp);
    int n;
    logic v;
    v = t ? tone_clk_out : aux_clk_out;
    while ((t ? tone_clk_out : aux_clk_out) === v) begin
      @(posedge clock);
      #1;
    end
    v = t ? tone_clk_out : aux_clk_out;
    n = 0;
    while ((t ? tone_clk_out : aux_clk_out) === v) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("half period", n, exp);
  endtask
  task t_regs;
    access(1'b0, 8'h03, 8'h00);
    chk("aux config", rdata, 32'h0000_002A);
    access(1'b0, 8'h04, 8'h00);
    chk("tone divider", rdata, 32'h0000_008E);
    access(1'b1, 8'h07, 8'h55);
    access(1'b0, 8'h07, 8'h00);
    chk("unmapped", rdata, 32'h0000_0000);
  endtask
  task t_port;
    for (int i = 0; i < 3; i++) begin
      access(1'b1, 8'h03, (i == 1) ? 8'h1E : 8'h01);
      repeat (2) @(posedge clock);
      #1;
      chk("aux level", aux_clk_out, 32'(i != 1));
    end
  endtask
  task t_hf;
    for (int n = 1; n < 4; n++) begin
      access(1'b1, 8'h03, {3'h1, 5'(n)});
      half(1'b0, 4 * n);
    end
    while (aux_clk_out !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    access(1'b1, 8'h03, 8'h20);
    chk("aux restart", aux_clk_out, 32'h0000_0000);
    repeat (20) @(posedge clock);
    #1;
    chk("aux zero div", aux_clk_out, 32'h0000_0000);
  endtask
  task t_lf;
    for (int k = 2; k < 8; k++) begin
      access(1'b1, 8'h03, {3'(k), 5'h1F});
      repeat (8) @(posedge clock);
      #1;
      chk("aux slow", aux_clk_out, 32'h0000_0000);
    end
    access(1'b0, 8'h03, 8'h00);
    chk("aux config", rdata, 32'h0000_00FF);
  endtask
  task t_tone;
    access(1'b1, 8'h04, 8'h01);
    half(1'b1, 64);
    access(1'b1, 8'h04, 8'h02);
    half(1'b1, 128);
    while (tone_clk_out !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    access(1'b0, 8'h04, 8'h00);
    chk("tone restart", tone_clk_out, 32'h0000_0000);
    chk("tone divider", rdata, 32'h0000_0002);
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_port();
    t_hf();
    t_lf();
    t_tone();
    summarize();
  end
  // Whole run needs well under 3000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
endmodule
